// File: common/dpmt_map.svh
`ifndef DPMT_MAP_SVH
`define DPMT_MAP_SVH
// ****************************************************************
// code point priority map constants
// ****************************************************************
// Overview of operation
// - map register 0 at byte 30h..35h holds fields for points 0..15.
// - map register 1 at byte 36h..3Bh holds fields for points 16..31.
// - map register 2 at byte 3Ch..41h holds fields for points 32..47.
// - map register 3 at byte 42h..47h holds fields for points 48..63.
// - lowest point of a group sits in bits 2:0, highest in bits 47:45.
// - reset clears every 3-bit field to zero.
// - every field is read/write and reads back the last written value.
// - a frame's six code point bits select one field as its priority.
// - lookup applies only on ports whose per-port enable bit is set.
// - layer select 01 gives the mapped priority, or zero if disabled.
// - layer select 10 gives IP frames mapped priority, else layer 2.
// - layer select 11 takes the max of port, mapped and 802.1p prio.
`define DPMT_MAP0_OFS 8'h30
`define DPMT_MAP1_OFS 8'h36
`define DPMT_MAP2_OFS 8'h3C
`define DPMT_MAP3_OFS 8'h42
`define DPMT_MAP_END 8'h48
`define DPMT_BYTES_PER_MAP 6
`define DPMT_FIELD_W 3
`define DPMT_FIELD_RST 3'h0
`define DPMT_ENABLE_OFS 8'h08
`define DPMT_ENABLE_BYTES 3
`define DPMT_ENABLE_RST 17'h00000
`define DPMT_LSEL_OFS 8'h00
`define DPMT_LSEL_LSB 2
`define DPMT_LSEL_RST 2'h0
`endif

// File: common/dpmt_pkg.sv
package dpmt_pkg;
  // layer selection modes
  typedef enum logic [1:0] {
    DPMT_L2_ONLY = 2'b00,
    DPMT_IP_ONLY = 2'b01,
    DPMT_IP_ELSE_L2 = 2'b10,
    DPMT_MAX_ALL = 2'b11
  } dpmt_lsel_e;
  typedef logic [2:0] dpmt_prio_t;
endpackage

// File: hw/dpmt_select.sv
`timescale 1ns/10ps
// ****************************************************************
// priority selection by layer mode
// ****************************************************************
module dpmt_select
  import dpmt_pkg::*;
(
  // mode and qualifiers
  input wire logic [1:0] layer_sel,
  input wire logic is_ip,
  input wire logic cp_enabled,
  input wire logic l2_valid,
  // candidate priorities
  input wire logic [2:0] cp_prio,
  input wire logic [2:0] port_prio,
  input wire logic [2:0] l2_prio,
  // result
  output logic [2:0] sel_prio
);
  logic [2:0] cp_gated;
  logic [2:0] l2_gated;
  logic [2:0] max_a;

  // disabled code point counts as zero; invalid 802.1p priority counts as zero in max mode only
  assign cp_gated = cp_enabled ? cp_prio : 3'h0;
  assign l2_gated = l2_valid ? l2_prio : 3'h0;
  assign max_a = (port_prio > cp_gated) ? port_prio : cp_gated;

  // pick by mode
  always_comb begin
    case (dpmt_lsel_e'(layer_sel))
      DPMT_L2_ONLY: sel_prio = l2_prio;
      DPMT_IP_ONLY: sel_prio = cp_gated;
      DPMT_IP_ELSE_L2: sel_prio = is_ip ? cp_gated : l2_prio;
      DPMT_MAX_ALL: sel_prio = (max_a > l2_gated) ? max_a : l2_gated;
      default: sel_prio = 3'h0;
    endcase
  end
endmodule

// File: hw/dpmt_table.sv
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`include "dpmt_map.svh"
// ****************************************************************
// code point priority map table with byte register port
// ****************************************************************
module dpmt_table
  import dpmt_pkg::*;
#(
  parameter int PORTS = 17
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // classifier request
  input wire logic cls_valid,
  input wire logic [4:0] cls_port,
  input wire logic [5:0] cls_codepoint,
  input wire logic cls_is_ip,
  input wire logic [2:0] cls_port_prio,
  input wire logic [2:0] cls_l2_prio,
  input wire logic cls_l2_valid,
  // classifier answer
  output logic prio_valid,
  output logic [2:0] prio_id,
  output logic [2:0] prio_codepoint_id
);
  localparam int ENTRIES = 64;
  localparam int TBL_BYTES = 4 * `DPMT_BYTES_PER_MAP;

  // flat table, entry n at bits 3n+2:3n
  logic [ENTRIES*3-1:0] table_reg;
  logic [PORTS-1:0] per_port_codepoint_enable;
  logic [1:0] layer_sel_reg;
  logic [7:0] rdata_next;
  logic [2:0] cp_prio;
  logic [2:0] sel_prio;
  logic port_en;
  logic tbl_hit;
  logic [4:0] tbl_byte;

  // ****************************************************************
  // byte decode
  // ****************************************************************
  // the four 48-bit registers are contiguous, so one byte index covers all
  assign tbl_hit = (reg_addr >= `DPMT_MAP0_OFS) &&
                   (reg_addr < `DPMT_MAP_END);
  assign tbl_byte = 5'(reg_addr - `DPMT_MAP0_OFS);

  // ****************************************************************
  // table storage
  // ****************************************************************
  genvar gb;
  generate
    for (gb = 0; gb < TBL_BYTES; gb++) begin : g_byte
      // each byte lane of the table, lowest address is least significant
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          table_reg[gb*8 +: 8] <= 8'h00;
        end else if (reg_wr && tbl_hit && tbl_byte == 5'(gb)) begin
          table_reg[gb*8 +: 8] <= reg_wdata;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // control registers
  // ****************************************************************
  // per port enable, bits 16:0 are ports 16..0, three bytes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      per_port_codepoint_enable <= PORTS'(`DPMT_ENABLE_RST);
    end else if (reg_wr) begin
      for (int i = 0; i < PORTS; i++) begin
        if (reg_addr == `DPMT_ENABLE_OFS + 8'(i / 8)) begin
          per_port_codepoint_enable[i] <= reg_wdata[i % 8];
        end
      end
    end
  end

  // layer selection field
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      layer_sel_reg <= `DPMT_LSEL_RST;
    end else if (reg_wr && reg_addr == `DPMT_LSEL_OFS) begin
      layer_sel_reg <= reg_wdata[`DPMT_LSEL_LSB +: 2];
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    rdata_next = 8'h00;
    if (tbl_hit) begin
      rdata_next = table_reg[tbl_byte*8 +: 8];
    end else if (reg_addr == `DPMT_LSEL_OFS) begin
      rdata_next[`DPMT_LSEL_LSB +: 2] = layer_sel_reg;
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        if (reg_addr == `DPMT_ENABLE_OFS + 8'(i / 8)) begin
          rdata_next[i % 8] = per_port_codepoint_enable[i];
        end
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************************************
  // lookup
  // ****************************************************************
  assign cp_prio = table_reg[cls_codepoint*3 +: 3];
  assign port_en = (cls_port < 5'(PORTS)) &&
                   per_port_codepoint_enable[cls_port];

  dpmt_select u_select (
    .layer_sel(layer_sel_reg),
    .is_ip(cls_is_ip),
    .cp_enabled(port_en),
    .l2_valid(cls_l2_valid),
    .cp_prio(cp_prio),
    .port_prio(cls_port_prio),
    .l2_prio(cls_l2_prio),
    .sel_prio(sel_prio)
  );

  // registered answer, one cycle after request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prio_valid <= 1'b0;
      prio_id <= 3'h0;
      prio_codepoint_id <= 3'h0;
    end else begin
      prio_valid <= cls_valid;
      if (cls_valid) begin
        prio_id <= sel_prio;
        prio_codepoint_id <= port_en ? cp_prio : 3'h0;
      end
    end
  end
endmodule

// File: bench/dpmt_table_props.sv
`timescale 1ns/10ps
// ********
// map table port checks
// ********
module dpmt_table_props
  import dpmt_pkg::*;
#(
  parameter int PORTS = 17
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // classifier
  input wire logic cls_valid,
  input wire logic [4:0] cls_port,
  input wire logic cls_is_ip,
  input wire logic [2:0] cls_port_prio,
  input wire logic prio_valid,
  input wire logic [2:0] prio_id,
  input wire logic [2:0] prio_codepoint_id
);
  logic [1:0] lsel_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // mirror of the layer select field
  always_ff @(posedge sys_clk) begin
    if (rst) lsel_reg <= 2'h0;
    else if (reg_wr && reg_addr == 8'h00) lsel_reg <= reg_wdata[3:2];
  end
  chk_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_unmapped_zero: assert property
    (reg_rd && reg_addr >= 8'h48 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_answer_next: assert property (cls_valid |=> prio_valid)
    else $error("no answer after request");
  chk_out_hold: assert property
    (!cls_valid |=> $stable(prio_id) && $stable(prio_codepoint_id))
    else $error("priority changed without request");
  chk_port_off: assert property
    (cls_valid && cls_port >= PORTS |=> prio_codepoint_id == 3'h0)
    else $error("lookup on disabled port");
  chk_ip_only: assert property
    (cls_valid && lsel_reg == 2'b01 |=> prio_id == prio_codepoint_id)
    else $error("ip only mode wrong");
  chk_ip_else: assert property
    (cls_valid && lsel_reg == 2'b10 && cls_is_ip
     |=> prio_id == prio_codepoint_id)
    else $error("ip frame mode wrong");
  chk_max_all: assert property
    (cls_valid && lsel_reg == 2'b11 |=> prio_id >= prio_codepoint_id
     && prio_id >= $past(cls_port_prio))
    else $error("max mode wrong");
  cover property (reg_rd ##1 reg_rdata != 8'h00);
  cover property (cls_valid && lsel_reg == 2'b11);
  cover property (cls_valid && cls_port >= PORTS);
endmodule
bind dpmt_table dpmt_table_props #(.PORTS(PORTS)) u_props (.sys_clk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cls_valid,
  .cls_port, .cls_is_ip, .cls_port_prio, .prio_valid, .prio_id,
  .prio_codepoint_id);

// File: bench/dpmt_table_tb.sv
`timescale 1ns/10ps
`include "dpmt_map.svh"
// ********
// map table bench
// ********
module dpmt_table_tb;
  logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, cls_valid = 0;
  logic cls_is_ip = 0, cls_l2_valid = 1, prio_valid;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [4:0] cls_port = 0;
  logic [5:0] cls_codepoint = 0;
  logic [2:0] cls_port_prio = 0, cls_l2_prio = 0, prio_id, prio_codepoint_id;
  logic [191:0] tbl;
  int n_errors = 0, n_compared = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  dpmt_table DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cls_valid, .cls_port, .cls_codepoint, .cls_is_ip,
    .cls_port_prio, .cls_l2_prio, .cls_l2_valid, .prio_valid, .prio_id,
    .prio_codepoint_id);
  // test pattern for one code point field
  function automatic logic [2:0] fv(int c);
    return 3'(c * 5 + (c >> 4));
  endfunction
  task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 cmp("rdata", e, reg_rdata);
  endtask
  // one lookup; answer packs valid, table field and final priority
  task automatic lk(logic [4:0] p, logic [5:0] c, logic ip,
    logic [2:0] pp, logic [2:0] lp, logic [2:0] e, logic [2:0] ec);
    @(posedge sys_clk);
    cls_valid <= 1'b1;
    cls_port <= p;
    cls_codepoint <= c;
    cls_is_ip <= ip;
    cls_port_prio <= pp;
    cls_l2_prio <= lp;
    @(posedge sys_clk);
    cls_valid <= 1'b0;
    #1 cmp("answer", {1'b1, ec, 1'b0, e},
      {prio_valid, prio_codepoint_id, 1'b0, prio_id});
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 24; i++) rd(`DPMT_MAP0_OFS + 8'(i), 8'h00);
    for (int c = 0; c < 64; c++) tbl[3*c +: 3] = fv(c);
    for (int i = 0; i < 24; i++) wr(8'h30 + 8'(i), tbl[8*i +: 8]);
    for (int i = 0; i < 24; i++) rd(8'h30 + 8'(i), tbl[8*i +: 8]);
    wr(`DPMT_MAP_END, 8'hFF);
    rd(`DPMT_MAP_END, 8'h00);
    wr(`DPMT_ENABLE_OFS + 8'h02, 8'h01);
    wr(`DPMT_LSEL_OFS, 8'h04);
    for (int c = 0; c < 64; c++) lk(16, 6'(c), 1, 0, 0, fv(c), fv(c));
    lk(0, 6'h3F, 1, 0, 0, 3'h0, 3'h0);
    lk(17, 6'h3F, 1, 0, 0, 3'h0, 3'h0);
    wr(`DPMT_LSEL_OFS, 8'h08);
    lk(16, 6'h21, 1, 0, 2, fv(33), fv(33));
    lk(16, 6'h21, 0, 0, 2, 3'h2, fv(33));
    wr(`DPMT_LSEL_OFS, 8'h0C);
    lk(16, 6'h10, 1, 2, 4, 3'h4, fv(16));
    lk(16, 6'h10, 1, 5, 3, 3'h5, fv(16));
    // max mode ignores the 802.1p priority when it is not valid
    @(posedge sys_clk) cls_l2_valid <= 1'b0;
    lk(16, 6'h10, 1, 2, 7, 3'h2, fv(16));
    // layer 2 only mode passes the layer 2 priority through
    wr(`DPMT_LSEL_OFS, 8'h00);
    lk(16, 6'h10, 1, 5, 6, 3'h6, fv(16));
    print_verdict();
  end
endmodule
